/* tape_load_pkg.sv */
// constants shared by the tape load sequencer and its helpers
package tape_load_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int DEBOUNCE_US = 1000;
	localparam int UNREEL_DELAY_MS = 200;
	localparam int FAULT_TIMEOUT_MS = 5000;
	localparam int SETTLE_HOLD_MS = 500;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1_000_000);
	localparam int UNREEL_DELAY_CYCLES = UNREEL_DELAY_MS * (CLK_HZ / 1000);
	localparam int FAULT_TIMEOUT_CYCLES = FAULT_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int SETTLE_HOLD_CYCLES = SETTLE_HOLD_MS * (CLK_HZ / 1000);
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam int CTRL_DOUBLE_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int ST_STAGE_ONE = 0;
	localparam int ST_FWD_SEEK = 1;
	localparam int ST_SETTLE = 2;
	localparam int ST_LOADED = 3;
	localparam int ST_FAULT = 4;
	localparam int ST_MOTOR = 5;
	localparam int ST_VACUUM = 6;
	localparam int ST_REEL_PWR = 7;
	localparam int ST_UNREEL = 8;
	localparam int ST_INDICATOR = 9;
	localparam logic [7:0] UNREEL_TORQUE = 8'h20;
endpackage

/* delay_if.sv */
// run/done pair between the sequencer and one delay counter
`timescale 1ns/1ps
interface delay_if;
	logic run;
	logic done;
	modport ctrl (output run, input done);
	modport timer (input run, output done);
endinterface

/* input_filter.sv */
// two-flop synchroniser and stable-count debouncer per input bit
`timescale 1ns/1ps
module input_filter #(
	parameter int WIDTH = 4,
	parameter int CYCLES = tape_load_pkg::DEBOUNCE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] clean
);
	if (CYCLES < 1 || WIDTH < 1) begin : g_check
		$error("input_filter: CYCLES and WIDTH must be at least 1");
	end
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] sync;
	logic [WIDTH-1:0][31:0] cnt;
	logic [WIDTH-1:0][31:0] next_cnt;
	logic [WIDTH-1:0] next_clean;
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_cnt[i] = 32'h0000_0000;
			next_clean[i] = clean[i];
			// level must hold for CYCLES edges before it is believed
			if (sync[i] != clean[i]) begin
				if (cnt[i] >= 32'(CYCLES - 1)) begin
					next_clean[i] = sync[i];
				end else begin
					next_cnt[i] = cnt[i] + 32'h0000_0001;
				end
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			sync <= '0;
			cnt <= '0;
			clean <= '0;
		end else begin
			meta <= raw;
			sync <= meta;
			cnt <= next_cnt;
			clean <= next_clean;
		end
	end
endmodule

/* delay_timer.sv */
// counter that reports done once run has been held for CYCLES edges
`timescale 1ns/1ps
module delay_timer #(
	parameter int CYCLES = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	delay_if.timer port
);
	if (CYCLES < 1) begin : g_check
		$error("delay_timer: CYCLES must be at least 1");
	end
	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic next_done;
	always_comb begin
		next_cnt = 32'h0000_0000;
		next_done = 1'b0;
		// dropping run clears the count at once, like a discharged capacitor
		if (port.run) begin
			if (cnt >= 32'(CYCLES - 1)) begin
				next_cnt = cnt;
				next_done = 1'b1;
			end else begin
				next_cnt = cnt + 32'h0000_0001;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 32'h0000_0000;
			port.done <= 1'b0;
		end else begin
			cnt <= next_cnt;
			port.done <= next_done;
		end
	end
endmodule

/* tape_load_sequencer.sv */
// automatic load sequencer for a vacuum-column tape transport, APB slave
// How it works
// - reel power relay on unless rewinding
// - button press-release pulse sets stage one
// - first pulse cannot start forward seek
// - stage one drives vacuum relay and blower
// - unreel enable needs stage, clear, delay
// - unreel delay starts when stage one sets
// - unreel enable applies small unreel torque
// - fault timeout aborts load, clears stage one
// - interlock in time cancels fault timer
// - column tape present starts settle hold
// - tape present energizes motor connect relay
// - latched interlock with power-good holds relay
// - settle done clears stage one
// - single press: stage end starts seek
// - double press: second press starts seek
// - start mark during seek stops tape
// - stopped under tension lights loaded lamp
// - power-good low initializes sequencer state
`timescale 1ns/1ps
module tape_load_sequencer #(
	parameter int DEBOUNCE_CYC = tape_load_pkg::DEBOUNCE_CYCLES,
	parameter int UNREEL_DELAY_CYC = tape_load_pkg::UNREEL_DELAY_CYCLES,
	parameter int FAULT_TIMEOUT_CYC = tape_load_pkg::FAULT_TIMEOUT_CYCLES,
	parameter int SETTLE_HOLD_CYC = tape_load_pkg::SETTLE_HOLD_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic load_button,
	input wire logic column_vacuum_ok,
	input wire logic column_gate_ok,
	input wire logic tape_start_mark,
	input wire logic rewind_active_n,
	input wire logic power_good_n_reset,
	input wire logic vacuum_request_n,
	output logic reel_power_relay,
	output logic vacuum_motor_relay,
	output logic motor_connect_relay,
	output logic unreel_enable_n,
	output logic [7:0] unreel_torque,
	output logic capstan_forward,
	output logic load_fault_n,
	output logic loaded_indicator
);
	if (DEBOUNCE_CYC < 1 || UNREEL_DELAY_CYC < 1 || FAULT_TIMEOUT_CYC < 1
		|| SETTLE_HOLD_CYC < 1) begin : g_check
		$error("tape_load_sequencer: every cycle count must be at least 1");
	end

	// ---------------- input conditioning
	logic [3:0] clean;
	logic btn;
	logic btn_prev;
	logic press_pulse;
	logic vac_ok;
	logic gate_ok;
	logic mark;
	input_filter #(.WIDTH(4), .CYCLES(DEBOUNCE_CYC)) u_filter (
		.pclk(pclk),
		.presetn(presetn),
		.raw({tape_start_mark, column_gate_ok, column_vacuum_ok, load_button}),
		.clean(clean)
	);
	assign btn = clean[0];
	assign vac_ok = clean[1];
	assign gate_ok = clean[2];
	assign mark = clean[3];
	assign press_pulse = btn_prev & ~btn;

	// ---------------- delay counters
	delay_if unreel_dly ();
	delay_if fault_dly ();
	delay_if settle_dly ();
	delay_timer #(.CYCLES(UNREEL_DELAY_CYC)) u_unreel (
		.pclk(pclk),
		.presetn(presetn),
		.port(unreel_dly.timer)
	);
	delay_timer #(.CYCLES(FAULT_TIMEOUT_CYC)) u_fault (
		.pclk(pclk),
		.presetn(presetn),
		.port(fault_dly.timer)
	);
	delay_timer #(.CYCLES(SETTLE_HOLD_CYC)) u_settle (
		.pclk(pclk),
		.presetn(presetn),
		.port(settle_dly.timer)
	);

	// ---------------- sequencer state
	logic double_press;
	logic load_stage_one;
	logic forward_seek_stage;
	logic tape_loaded_n;
	logic settle_done;
	logic seek_stop_n;
	logic interlock_latched;
	logic column_tape_present_n;
	logic unreel_delay_done;
	logic interlock_clear;
	logic pg;
	logic next_load_stage_one;
	logic next_forward_seek_stage;
	logic next_tape_loaded_n;
	logic next_settle_done;
	logic next_seek_stop_n;
	logic next_interlock_latched;
	logic next_column_tape_present_n;
	logic next_reel_power_relay;
	logic next_vacuum_motor_relay;
	logic next_motor_connect_relay;
	logic next_unreel_enable_n;
	logic [7:0] next_unreel_torque;
	logic next_capstan_forward;
	logic next_load_fault_n;
	logic next_loaded_indicator;
	logic seek_start;

	assign pg = power_good_n_reset;
	assign unreel_delay_done = unreel_dly.done;
	// high until the relay is in and both column switches report tape
	assign interlock_clear = ~(motor_connect_relay & vac_ok & gate_ok);
	assign unreel_dly.run = load_stage_one;
	assign fault_dly.run = ~unreel_enable_n;
	assign settle_dly.run = ~column_tape_present_n & ~settle_done;

	always_comb begin
		// seek only once the interlock stands, so the first press is inert
		seek_start = 1'b0;
		if (tape_loaded_n && seek_stop_n) begin
			if (double_press) begin
				seek_start = press_pulse & settle_done;
			end else begin
				seek_start = load_stage_one & settle_dly.done;
			end
		end
		next_load_stage_one = (press_pulse & ~settle_done)
			| (load_stage_one & ~fault_dly.done & ~settle_done);
		next_settle_done = (settle_done | settle_dly.done) & ~column_tape_present_n;
		next_forward_seek_stage = seek_start | (forward_seek_stage & seek_stop_n);
		next_tape_loaded_n = tape_loaded_n & ~seek_start;
		next_seek_stop_n = ~(interlock_clear | (mark & forward_seek_stage));
		next_column_tape_present_n = ~(vac_ok & gate_ok);
		// latch sees only relay and vac_ok, not gate_ok, so a gate drop alone keeps the relay
		next_interlock_latched = motor_connect_relay & vac_ok;
		next_motor_connect_relay = ~column_tape_present_n
			| interlock_latched;
		next_unreel_enable_n = ~(load_stage_one & interlock_clear
			& unreel_delay_done);
		// the fault flag is hardware-set and cleared by the next press; set wins
		next_load_fault_n = ~fault_dly.done & (load_fault_n | press_pulse);
		if (!pg) begin
			next_load_stage_one = 1'b0;
			next_settle_done = 1'b0;
			next_forward_seek_stage = 1'b0;
			next_tape_loaded_n = 1'b1;
			next_interlock_latched = 1'b0;
			next_motor_connect_relay = 1'b0;
			next_unreel_enable_n = 1'b1;
			next_load_fault_n = 1'b1;
		end
		next_unreel_torque = next_unreel_enable_n ? 8'h00
			: tape_load_pkg::UNREEL_TORQUE;
		next_capstan_forward = next_forward_seek_stage;
		next_reel_power_relay = rewind_active_n;
		next_vacuum_motor_relay = ~(~next_load_stage_one & vacuum_request_n);
		next_loaded_indicator = ~tape_loaded_n & ~forward_seek_stage
			& ~interlock_clear;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			btn_prev <= 1'b0;
			load_stage_one <= 1'b0;
			forward_seek_stage <= 1'b0;
			tape_loaded_n <= 1'b1;
			settle_done <= 1'b0;
			seek_stop_n <= 1'b0;
			interlock_latched <= 1'b0;
			column_tape_present_n <= 1'b1;
			reel_power_relay <= 1'b1;
			vacuum_motor_relay <= 1'b0;
			motor_connect_relay <= 1'b0;
			unreel_enable_n <= 1'b1;
			unreel_torque <= 8'h00;
			capstan_forward <= 1'b0;
			load_fault_n <= 1'b1;
			loaded_indicator <= 1'b0;
		end else begin
			btn_prev <= btn;
			load_stage_one <= next_load_stage_one;
			forward_seek_stage <= next_forward_seek_stage;
			tape_loaded_n <= next_tape_loaded_n;
			settle_done <= next_settle_done;
			seek_stop_n <= next_seek_stop_n;
			interlock_latched <= next_interlock_latched;
			column_tape_present_n <= next_column_tape_present_n;
			reel_power_relay <= next_reel_power_relay;
			vacuum_motor_relay <= next_vacuum_motor_relay;
			motor_connect_relay <= next_motor_connect_relay;
			unreel_enable_n <= next_unreel_enable_n;
			unreel_torque <= next_unreel_torque;
			capstan_forward <= next_capstan_forward;
			load_fault_n <= next_load_fault_n;
			loaded_indicator <= next_loaded_indicator;
		end
	end

	// ---------------- APB slave, one wait state on every transfer
	logic [31:0] status;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_double_press;
	logic hit_ctrl;
	logic hit_status;

	always_comb begin
		status = 32'h0000_0000;
		status[tape_load_pkg::ST_STAGE_ONE] = load_stage_one;
		status[tape_load_pkg::ST_FWD_SEEK] = forward_seek_stage;
		status[tape_load_pkg::ST_SETTLE] = settle_done;
		status[tape_load_pkg::ST_LOADED] = ~tape_loaded_n;
		status[tape_load_pkg::ST_FAULT] = ~load_fault_n;
		status[tape_load_pkg::ST_MOTOR] = motor_connect_relay;
		status[tape_load_pkg::ST_VACUUM] = vacuum_motor_relay;
		status[tape_load_pkg::ST_REEL_PWR] = reel_power_relay;
		status[tape_load_pkg::ST_UNREEL] = ~unreel_enable_n;
		status[tape_load_pkg::ST_INDICATOR] = loaded_indicator;
	end

	always_comb begin
		hit_ctrl = paddr == tape_load_pkg::CTRL_OFFSET;
		hit_status = paddr == tape_load_pkg::STATUS_OFFSET;
		next_pready = psel & penable & ~pready;
		next_pslverr = 1'b0;
		next_prdata = 32'h0000_0000;
		next_double_press = double_press;
		if (psel && penable && !pready) begin
			next_pslverr = ~(hit_ctrl | hit_status);
			if (!pwrite && hit_ctrl) begin
				next_prdata = {31'h0000_0000, double_press};
			end else if (!pwrite && hit_status) begin
				next_prdata = status;
			end
		end
		if (psel && penable && pready && pwrite && hit_ctrl) begin
			next_double_press = pwdata[tape_load_pkg::CTRL_DOUBLE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			double_press <= tape_load_pkg::CTRL_RESET[tape_load_pkg::CTRL_DOUBLE_BIT];
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			double_press <= next_double_press;
		end
	end

	// ---------------- checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_REEL_POWER: assert property (
		##1 reel_power_relay == $past(rewind_active_n))
		else $error("reel power relay does not follow rewind state");
	AST_VACUUM_ON: assert property (
		load_stage_one |-> vacuum_motor_relay)
		else $error("vacuum relay off during stage one");
	AST_UNREEL_CAUSE: assert property (
		$fell(unreel_enable_n) |-> $past(load_stage_one && interlock_clear && unreel_delay_done))
		else $error("unreel enabled without its three conditions");
	AST_DELAY_AFTER_STAGE: assert property (
		$rose(unreel_delay_done) |-> $past(load_stage_one))
		else $error("unreel delay finished without stage one");
	AST_FAULT_ABORT: assert property (
		fault_dly.done && pg |=> !load_fault_n && !load_stage_one)
		else $error("fault timeout did not abort the load");
	AST_RELAY_ON_TAPE: assert property (
		!column_tape_present_n && pg |=> motor_connect_relay)
		else $error("motor connect relay off with tape present");
	AST_RELAY_DROP: assert property (
		!pg |=> !motor_connect_relay && !load_stage_one && !forward_seek_stage)
		else $error("power-good low left sequencer state standing");
	AST_SETTLE_CLEARS: assert property (
		settle_done && pg && !press_pulse |=> !load_stage_one)
		else $error("settle done did not clear stage one");
	AST_SEEK_STOP: assert property (
		forward_seek_stage && mark && !interlock_clear && pg
		|=> !seek_stop_n ##1 !forward_seek_stage)
		else $error("start mark did not stop the forward seek");
	AST_INDICATOR: assert property (
		loaded_indicator |-> $past(!tape_loaded_n && !forward_seek_stage))
		else $error("loaded lamp lit before tape stopped");
endmodule

/* tape_operator_model.sv */
// operator pushbutton, column switches and start-mark sensor model
`timescale 1ns/1ps
module tape_operator_model (
	input wire logic pclk,
	input wire logic unreel_enable_n,
	input wire logic capstan_forward,
	output logic load_button,
	output logic column_vacuum_ok,
	output logic column_gate_ok,
	output logic tape_start_mark
);
	int fill_cyc = 3;
	int feed_cnt = 0;
	int seek_cnt = 0;
	logic feed = 1'b1;
	logic gate_hold = 1'b0;
	initial begin
		load_button = 1'b0;
	end
	// held well past the debouncer; release is what loads
	task automatic press(input int hold);
		@(posedge pclk);
		load_button <= 1'b1;
		repeat (hold) @(posedge pclk);
		load_button <= 1'b0;
	endtask
	// a large fill_cyc models a tape that never reaches the columns
	always @(posedge pclk) begin
		if (!feed) begin
			feed_cnt <= 0;
			seek_cnt <= 0;
		end else if (!unreel_enable_n) begin
			feed_cnt <= feed_cnt + 1;
			seek_cnt <= 0;
		end else if (capstan_forward) begin
			seek_cnt <= seek_cnt + 1;
		end
		column_vacuum_ok <= feed && feed_cnt >= fill_cyc;
		column_gate_ok <= feed && feed_cnt >= fill_cyc && !gate_hold;
		tape_start_mark <= feed && seek_cnt >= 4;
	end
endmodule

/* tape_load_sequencer_test.sv */
// self-checking bench for the tape load sequencer
`timescale 1ns/1ps
module tape_load_sequencer_test;
	localparam int UNR = 4;
	localparam int FLT = 20;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic load_button, column_vacuum_ok, column_gate_ok, tape_start_mark;
	logic rewind_active_n = 1'b1;
	logic power_good_n_reset = 1'b1;
	logic vacuum_request_n = 1'b1;
	logic reel_power_relay, vacuum_motor_relay, motor_connect_relay;
	logic unreel_enable_n, capstan_forward, load_fault_n, loaded_indicator;
	logic [7:0] unreel_torque;
	logic [31:0] rd;
	logic err;
	int errors = 0;
	int total_checks = 0;
	int cyc;
	always #5 pclk = ~pclk;
	tape_load_sequencer #(.DEBOUNCE_CYC(2), .UNREEL_DELAY_CYC(UNR),
		.FAULT_TIMEOUT_CYC(FLT), .SETTLE_HOLD_CYC(4)) u_tape_load_sequencer (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.load_button(load_button),
		.column_vacuum_ok(column_vacuum_ok),
		.column_gate_ok(column_gate_ok),
		.tape_start_mark(tape_start_mark),
		.rewind_active_n(rewind_active_n),
		.power_good_n_reset(power_good_n_reset),
		.vacuum_request_n(vacuum_request_n),
		.reel_power_relay(reel_power_relay),
		.vacuum_motor_relay(vacuum_motor_relay),
		.motor_connect_relay(motor_connect_relay),
		.unreel_enable_n(unreel_enable_n),
		.unreel_torque(unreel_torque),
		.capstan_forward(capstan_forward),
		.load_fault_n(load_fault_n),
		.loaded_indicator(loaded_indicator)
	);
	tape_operator_model u_tape_operator_model (.pclk(pclk),
		.unreel_enable_n(unreel_enable_n), .capstan_forward(capstan_forward),
		.load_button(load_button), .column_vacuum_ok(column_vacuum_ok),
		.column_gate_ok(column_gate_ok), .tape_start_mark(tape_start_mark));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			errors++;
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// no limit here: only the watchdog ends a wait for pready
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check("apb wait", 2, n);
	endtask
	function automatic logic pick(input int w);
		case (w)
			0: return vacuum_motor_relay;
			1: return unreel_enable_n;
			2: return motor_connect_relay;
			3: return capstan_forward;
			4: return load_fault_n;
			5: return loaded_indicator;
			default: return reel_power_relay;
		endcase
	endfunction
	task automatic wait_for(input string what, input int w, input logic v, input int lim);
		int n;
		for (n = 0; n < lim && pick(w) !== v; n++)
			@(posedge pclk);
		cyc = n;
		check(what, v, pick(w));
	endtask
	task automatic pg_reset;
		u_tape_operator_model.feed <= 1'b0;
		power_good_n_reset <= 1'b0;
		repeat (3) @(posedge pclk);
		power_good_n_reset <= 1'b1;
		check("pg motor", 0, motor_connect_relay);
		check("pg lamp", 0, loaded_indicator);
		u_tape_operator_model.feed <= 1'b1;
	endtask
	task automatic t_reset;
		check("reel power", 1, reel_power_relay);
		check("fault idle", 1, load_fault_n);
		check("unreel idle", 1, unreel_enable_n);
		check("vac idle", 0, vacuum_motor_relay);
		apb(1'b0, 8'h00, 32'h0);
		check("ctrl reset", 32'h0, rd);
		apb(1'b0, 8'h08, 32'h0);
		check("unmapped err", 1, err);
		$display("test reset done");
	endtask
	task automatic t_single;
		u_tape_operator_model.press(8);
		wait_for("vac on", 0, 1'b1, 20);
		check("no seek yet", 0, capstan_forward);
		wait_for("unreel on", 1, 1'b0, 40);
		check("unreel delay", 1, cyc >= UNR);
		check("torque", 32'h20, unreel_torque);
		wait_for("motor on", 2, 1'b1, 30);
		wait_for("unreel off", 1, 1'b1, 5);
		wait_for("seek", 3, 1'b1, 40);
		check("latched", 1, motor_connect_relay);
		wait_for("seek stop", 3, 1'b0, 20);
		wait_for("lamp", 5, 1'b1, 10);
		check("no fault", 1, load_fault_n);
		apb(1'b0, 8'h04, 32'h0);
		check("status", 32'h8, rd & 32'h1B);
		$display("test single load done");
	endtask
	task automatic t_hold;
		vacuum_request_n <= 1'b0;
		wait_for("vac request", 0, 1'b1, 5);
		vacuum_request_n <= 1'b1;
		rewind_active_n <= 1'b0;
		wait_for("rewind", 6, 1'b0, 5);
		rewind_active_n <= 1'b1;
		wait_for("no rewind", 6, 1'b1, 5);
		u_tape_operator_model.gate_hold <= 1'b1;
		wait_for("gate off lamp", 5, 1'b0, 12);
		repeat (3) @(posedge pclk);
		check("latch holds", 1, motor_connect_relay);
		u_tape_operator_model.gate_hold <= 1'b0;
		wait_for("gate back lamp", 5, 1'b1, 12);
		u_tape_operator_model.feed <= 1'b0;
		wait_for("switch open", 2, 1'b0, 10);
		$display("test hold done");
	endtask
	task automatic t_fault;
		pg_reset();
		u_tape_operator_model.fill_cyc <= 1000;
		u_tape_operator_model.press(8);
		wait_for("unreel on", 1, 1'b0, 40);
		wait_for("fault", 4, 1'b0, FLT + 10);
		check("fault time", 1, cyc >= FLT);
		wait_for("abort unreel", 1, 1'b1, 5);
		wait_for("abort vac", 0, 1'b0, 5);
		$display("test fault done");
	endtask
	task automatic t_double;
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b0, 8'h00, 32'h0);
		check("ctrl rw", 32'h1, rd);
		pg_reset();
		u_tape_operator_model.fill_cyc <= 3;
		u_tape_operator_model.press(8);
		wait_for("motor on", 2, 1'b1, 60);
		wait_for("stage end", 0, 1'b0, 40);
		repeat (5) @(posedge pclk);
		check("wait press", 0, capstan_forward);
		u_tape_operator_model.press(8);
		wait_for("seek", 3, 1'b1, 20);
		wait_for("seek stop", 3, 1'b0, 20);
		check("fault gone", 1, load_fault_n);
		$display("test double load done");
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		give_verdict();
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_single();
		t_hold();
		t_fault();
		t_double();
		give_verdict();
	end
endmodule
